/* File: hdl/ccg_osc_gen.sv */
// Free running oscillator model with programmable half period
`timescale 1ns/1ps
module ccg_osc_gen
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Half period in reference cycles, at least one
  input  wire logic [8:0] half_in,
  // One pulse per oscillator rising edge
  output logic            tick_out
);

  typedef struct packed
  {
    logic [8:0] cnt;
    logic       lvl;
    logic       tick;
  } ccg_osc_s;

  ccg_osc_s st_r;
  ccg_osc_s st_nxt;

  // Toggle after each half period; a longer half gives a lower rate
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt + 9'h001 >= half_in)
    begin
      st_nxt.cnt  = 9'h000;
      st_nxt.lvl  = ~st_r.lvl;
      st_nxt.tick = ~st_r.lvl;
    end
    else
      st_nxt.cnt = st_r.cnt + 9'h001;
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_out = st_r.tick;

endmodule

/* File: hdl/ccg_pin_sync.sv */
// Two-flop synchroniser with rising edge pulse for an oscillator pin
`timescale 1ns/1ps
module ccg_pin_sync
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Asynchronous pin and synchronised results
  input  wire logic pin_in,
  output logic      lvl_out,
  output logic      rise_out
);

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } ccg_sync_s;

  ccg_sync_s st_r;
  ccg_sync_s st_nxt;

  // First stage only feeds the second
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = pin_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign lvl_out  = st_r.s2;
  assign rise_out = st_r.rise;

endmodule

/* File: hdl/ccg_pkg.sv */
// Constants, types and register map of the clock source and output control block
// What this block does
// [RQ1] Machine cycle equals two CPU clock cycles
// [RQ2] Instructions take two or four CPU clocks
// [RQ3] Peripheral clock runs at half CPU clock
// [RQ4] Oscillator clock comes from one of four sources
// [RQ5] Source and range fixed by flash configuration
// [RQ6] Clock out enable drives crystal output pin
// [RQ7] No clock out while RTC uses crystal
// [RQ8] Clock out runs at half CPU clock
// [RQ9] RC select bit switches CPU clock immediately; the code switches on the next tick of the new source
// [RQ10] Reset loads factory trim, clears bits 7:6
// [RQ11] Larger trim value gives lower RC frequency
// [RQ12] RC oscillator nominal 7.373 MHz at factory trim
// [RQ13] Watchdog oscillator runs free at 400 kHz
// [RQ14] Software read-modify-writes bits 6 and 7
// [RQ15] Above 12 MHz configuration enables reset pin; the code enables no reset pin and only reports the range strap in status
// [RQ16] External clock 0 to 18 MHz, pin freed
// [RQ17] CPU clock is oscillator divided by 2N
// [RQ18] Only power-on reset reloads the tuning register
// [RQ19] Clock source switches without truncated pulses
package ccg_pkg;

  // ****************************************************************
  // Register map: printed offsets are indices, byte address is 4x
  // ****************************************************************
  localparam logic [11:0] IDX_TRIM   = 12'h096;
  localparam logic [11:0] IDX_CPU_CLOCK_DIVIDER   = 12'h097;
  localparam logic [11:0] IDX_STATUS = 12'h098;
  localparam logic [11:0] ADDR_TRIM   = {IDX_TRIM[9:0], 2'b00};
  localparam logic [11:0] ADDR_CPU_CLOCK_DIVIDER   = {IDX_CPU_CLOCK_DIVIDER[9:0], 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          TRIM_RC_SEL_BIT = 7;
  localparam int          TRIM_CLOCK_OUT_PIN_BIT = 6;
  localparam int          TRIM_VAL_W      = 6;
  localparam logic [5:0]  FACTORY_TRIM    = 6'h08;
  localparam logic [7:0]  CPU_CLOCK_DIVIDER_RESET      = 8'h00;
  localparam int          STAT_SRC_LSB    = 0;
  localparam int          STAT_RANGE_LSB  = 2;
  localparam int          STAT_RC_ACT_BIT = 4;
  localparam int          STAT_CLOCK_OUT_PIN_BIT = 5;
  localparam int          STAT_RTC_BIT    = 6;

  // ****************************************************************
  // Timing: ref clock and oscillator figures
  // ****************************************************************
  localparam int CLK_HZ      = 200_000_000;
  localparam int RC_NOM_HZ   = 7_373_000;
  localparam int WDT_HZ      = 400_000;
  localparam int RC_NOM_HALF = CLK_HZ / (2 * RC_NOM_HZ);
  localparam int WDT_HALF    = CLK_HZ / (2 * WDT_HZ);
  localparam logic [8:0] RC_HALF_BASE  = 9'(RC_NOM_HALF - int'(FACTORY_TRIM));
  localparam logic [8:0] WDT_HALF_CNT  = 9'(WDT_HALF);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SRC_WDT  = 2'h0,
    SRC_RC   = 2'h1,
    SRC_XTAL = 2'h2,
    SRC_EXT  = 2'h3
  } ccg_src_e;

  typedef struct packed
  {
    ccg_src_e   src;
    logic [1:0] range;
  } ccg_cfg_s;

endpackage

/* File: hdl/ccg_top.sv */
// Clock source selection, CPU divider, trim register and clock output pin
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module ccg_top
#(
  parameter logic [5:0] FACTORY_TRIM_VAL = ccg_pkg::FACTORY_TRIM
)
(
  // Clock and resets
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        SYS_RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Flash configuration straps
  input  wire logic [1:0]  CFG_SRC_IN,
  input  wire logic [1:0]  CFG_RANGE_IN,
  // Oscillator pins and RTC source
  input  wire logic        CRYSTAL_IN_PIN_IN,
  input  wire logic        RTC_USES_XTAL_IN,
  // Crystal output pin, port function when free
  input  wire logic        PORT_DATA_IN,
  input  wire logic        PORT_OE_IN,
  output logic             CRYSTAL_OUT_PIN_OUT,
  output logic             CRYSTAL_OUT_PIN_OE_OUT,
  // Derived clock pulses
  output logic             OSC_TICK_OUT,
  output logic             CPU_TICK_OUT,
  output logic             MACHINE_TICK_OUT,
  output logic             PERIPH_TICK_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  // All flops of this module outside the oscillator and synchroniser instances live in this one struct
  typedef struct packed
  {
    logic [7:0]       trim;
    logic [7:0]       cpu_clock_divider;
    logic             cfg_ok;
    ccg_pkg::ccg_cfg_s cfg;
    logic             rc_act;
    logic [8:0]       div_cnt;
    logic             osc_tick;
    logic             cpu_tick;
    logic             mc_ph;
    logic             mc_tick;
    logic             clock_out_pin;
    logic             pin_o;
    logic             pin_oe;
    logic [31:0]      prdata;
  } ccg_top_s;

  // Power-on image; a system reset keeps trim, straps and RC choice
  localparam ccg_top_s ST_RESET = '{
    trim:     {2'b00, FACTORY_TRIM_VAL},
    cpu_clock_divider:     ccg_pkg::CPU_CLOCK_DIVIDER_RESET,
    cfg_ok:   1'b0,
    cfg:      '{src: ccg_pkg::SRC_WDT, range: 2'b00},
    rc_act:   1'b0,
    div_cnt:  9'h000,
    osc_tick: 1'b0,
    cpu_tick: 1'b0,
    mc_ph:    1'b0,
    mc_tick:  1'b0,
    clock_out_pin:   1'b0,
    pin_o:    1'b0,
    pin_oe:   1'b0,
    prdata:   32'h0000_0000
  };

  // Current and next state
  ccg_top_s st_r;
  ccg_top_s st_nxt;

  // ****************************************************************
  // Oscillator sources
  // ****************************************************************
  // Oscillators are tick counters on the reference clock; a pin clock
  // near the reference rate would lose edges in the synchroniser
  logic       xtal_rise;
  logic       rc_tick;
  logic       wdt_tick;
  logic [8:0] rc_half;

  // Larger trim lengthens the half period, lowering the RC rate; see [RQ11] see [RQ12]
  assign rc_half = ccg_pkg::RC_HALF_BASE + {3'b000, st_r.trim[ccg_pkg::TRIM_VAL_W-1:0]};

  // Crystal and external clock both arrive on the crystal input pin; see [RQ16]
  ccg_pin_sync u_xtal_sync
  (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RST_IN),
    .pin_in   (CRYSTAL_IN_PIN_IN),
    .lvl_out  (),
    .rise_out (xtal_rise)
  );

  // Internal RC oscillator, tuned by the trim field
  ccg_osc_gen u_rc_osc
  (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RST_IN),
    .half_in  (rc_half),
    .tick_out (rc_tick)
  );

  // Watchdog oscillator runs regardless of selection; see [RQ13]
  ccg_osc_gen u_wdt_osc
  (
    .clk_in   (REF_CLK_IN),
    .rst_in   (RST_IN),
    .half_in  (ccg_pkg::WDT_HALF_CNT),
    .tick_out (wdt_tick)
  );

  // ****************************************************************
  // Source selection
  // ****************************************************************
  // Source tick before and after the RC override
  logic src_tick;
  logic sel_tick;
  logic want_rc;

  // Exactly one of four sources feeds the oscillator clock; see [RQ4]
  always_comb
  begin
    unique case (st_r.cfg.src)
      ccg_pkg::SRC_WDT:  src_tick = wdt_tick;
      ccg_pkg::SRC_RC:   src_tick = rc_tick;
      ccg_pkg::SRC_XTAL: src_tick = xtal_rise;
      ccg_pkg::SRC_EXT:  src_tick = xtal_rise;
    endcase
  end

  // RC select bit is read straight from the register
  assign want_rc  = st_r.trim[ccg_pkg::TRIM_RC_SEL_BIT];
  // Nothing ticks until the straps are captured
  assign sel_tick = st_r.cfg_ok & (st_r.rc_act ? rc_tick : src_tick);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Bus phases and address hits
  logic apb_setup;
  logic apb_access;
  logic hit_trim;
  logic hit_cpu_clock_divider;
  logic hit_stat;
  logic apb_wr;
  logic clock_out_pin_on;

  // Full address compare; upper strobes hold no register bits
  assign apb_setup  = PSEL_IN & ~PENABLE_IN;
  assign apb_access = PSEL_IN & PENABLE_IN;
  assign hit_trim   = (PADDR_IN == ccg_pkg::ADDR_TRIM);
  assign hit_cpu_clock_divider   = (PADDR_IN == ccg_pkg::ADDR_CPU_CLOCK_DIVIDER);
  assign hit_stat   = (PADDR_IN == ccg_pkg::ADDR_STATUS);
  assign apb_wr     = apb_access & PWRITE_IN & PSTRB_IN[0];

  // Clock out only when crystal is free and the RTC is not on it; see [RQ6] see [RQ7]
  assign clock_out_pin_on = st_r.trim[ccg_pkg::TRIM_CLOCK_OUT_PIN_BIT] & st_r.cfg_ok
                   & (st_r.cfg.src != ccg_pkg::SRC_XTAL) & ~RTC_USES_XTAL_IN;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_nxt          = st_r;
    // Pulses last one cycle unless set again below
    st_nxt.osc_tick = 1'b0;
    st_nxt.cpu_tick = 1'b0;
    st_nxt.mc_tick  = 1'b0;

    // Straps are sampled once after release, never by software; see [RQ5]
    if (!st_r.cfg_ok)
    begin
      st_nxt.cfg_ok    = 1'b1;
      st_nxt.cfg.src   = ccg_pkg::ccg_src_e'(CFG_SRC_IN);
      st_nxt.cfg.range = CFG_RANGE_IN;
    end

    // Switch only on an edge of the new source, swallowing it; see [RQ9] see [RQ19]
    if (st_r.rc_act != want_rc)
    begin
      // Waiting stalls the divider instead of cutting a pulse short
      if ((want_rc ? rc_tick : src_tick) && st_r.cfg_ok)
      begin
        st_nxt.rc_act  = want_rc;
        st_nxt.div_cnt = 9'h000;
      end
    end
    else if (sel_tick)
    begin
      st_nxt.osc_tick = 1'b1;
      // Divide by 2N, N of zero passes through; see [RQ17]
      if (st_r.cpu_clock_divider == 8'h00)
        st_nxt.cpu_tick = 1'b1;
      else if (st_r.div_cnt + 9'h001 >= {st_r.cpu_clock_divider, 1'b0})
      begin
        st_nxt.cpu_tick = 1'b1;
        st_nxt.div_cnt  = 9'h000;
      end
      else
        st_nxt.div_cnt = st_r.div_cnt + 9'h001;
    end

    // Every second CPU clock ends a machine and peripheral cycle; see [RQ1] see [RQ2] see [RQ3]
    if (st_r.cpu_tick)
    begin
      st_nxt.mc_ph   = ~st_r.mc_ph;
      st_nxt.mc_tick = st_r.mc_ph;
      // Output toggles per CPU clock, so half its rate; see [RQ8]
      st_nxt.clock_out_pin  = ~st_r.clock_out_pin;
    end

    // Registered so the pin never sees a decode glitch
    // Pin: clock out, else port, and never driven in crystal mode; see [RQ16]
    if (clock_out_pin_on)
    begin
      st_nxt.pin_o  = st_r.clock_out_pin;
      st_nxt.pin_oe = 1'b1;
    end
    else
    begin
      st_nxt.pin_o  = PORT_DATA_IN;
      st_nxt.pin_oe = PORT_OE_IN & st_r.cfg_ok & (st_r.cfg.src != ccg_pkg::SRC_XTAL);
    end

    // Register writes; all eight trim bits are written as given; see [RQ14]
    if (apb_wr && hit_trim)
      st_nxt.trim = PWDATA_IN[7:0];
    if (apb_wr && hit_cpu_clock_divider)
      st_nxt.cpu_clock_divider = PWDATA_IN[7:0];

    // Read data captured in setup, presented in access
    // Registered data costs no wait state, as access follows setup
    if (apb_setup)
    begin
      st_nxt.prdata = 32'h0000_0000;
      if (hit_trim)
        st_nxt.prdata[7:0] = st_r.trim;
      else if (hit_cpu_clock_divider)
        st_nxt.prdata[7:0] = st_r.cpu_clock_divider;
      else if (hit_stat)
      begin
        st_nxt.prdata[ccg_pkg::STAT_SRC_LSB +: 2]   = st_r.cfg.src;
        st_nxt.prdata[ccg_pkg::STAT_RANGE_LSB +: 2] = st_r.cfg.range;
        st_nxt.prdata[ccg_pkg::STAT_RC_ACT_BIT]     = st_r.rc_act;
        st_nxt.prdata[ccg_pkg::STAT_CLOCK_OUT_PIN_BIT]     = clock_out_pin_on;
        st_nxt.prdata[ccg_pkg::STAT_RTC_BIT]        = RTC_USES_XTAL_IN;
      end
    end

    // Other resets clear the clock path but keep trim and straps; see [RQ18]
    if (SYS_RST_IN)
    begin
      // Divider restarts from zero, so the first CPU clock is whole
      st_nxt          = ST_RESET;
      st_nxt.trim     = st_r.trim;
      st_nxt.cfg_ok   = st_r.cfg_ok;
      st_nxt.cfg      = st_r.cfg;
      st_nxt.rc_act   = st_r.rc_act;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-on reset loads factory trim, clears select bits; see [RQ10]
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero wait states; unmapped addresses answer with an error
  assign PREADY_OUT             = 1'b1;
  assign PSLVERR_OUT            = apb_access & ~(hit_trim | hit_cpu_clock_divider | hit_stat);
  assign PRDATA_OUT             = st_r.prdata;
  assign CRYSTAL_OUT_PIN_OUT    = st_r.pin_o;
  assign CRYSTAL_OUT_PIN_OE_OUT = st_r.pin_oe;
  assign OSC_TICK_OUT           = st_r.osc_tick;
  assign CPU_TICK_OUT           = st_r.cpu_tick;
  // Peripheral clock is the machine pulse: half the CPU rate
  assign MACHINE_TICK_OUT       = st_r.mc_tick;
  assign PERIPH_TICK_OUT        = st_r.mc_tick;

endmodule

/* File: tb/ccg_top_checker.sv */
// Port-level assertions for the clock source and output control block
`timescale 1ns/1ps
module ccg_top_checker
#(
  parameter logic [5:0] FACTORY_TRIM_VAL = ccg_pkg::FACTORY_TRIM
)
(
  // Clock and resets
  input wire logic        REF_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        SYS_RST_IN,
  // APB
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // Straps, pin and ticks
  input wire logic [1:0]  CFG_SRC_IN,
  input wire logic        RTC_USES_XTAL_IN,
  input wire logic        PORT_OE_IN,
  input wire logic        CRYSTAL_OUT_PIN_OE_OUT,
  input wire logic        OSC_TICK_OUT,
  input wire logic        CPU_TICK_OUT,
  input wire logic        MACHINE_TICK_OUT,
  input wire logic        PERIPH_TICK_OUT
);
  // Decode kept apart so a bad map in the design shows up
  logic unmapped;
  assign unmapped = !(PADDR_IN inside {ccg_pkg::ADDR_TRIM, ccg_pkg::ADDR_CPU_CLOCK_DIVIDER, ccg_pkg::ADDR_STATUS});
  default clocking dc @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN || SYS_RST_IN);

  // Clock tree relations
  cpu_on_osc_a: assert property (CPU_TICK_OUT |-> OSC_TICK_OUT) else $error("cpu tick off osc");
  periph_eq_a: assert property (PERIPH_TICK_OUT == MACHINE_TICK_OUT) else $error("periph tick");
  mach_after_a: assert property (MACHINE_TICK_OUT |-> $past(CPU_TICK_OUT)) else $error("machine tick");
  osc_pulse_a: assert property (OSC_TICK_OUT |=> !OSC_TICK_OUT) else $error("osc tick width");
  // Crystal output pin
  xtal_free_a: assert property (CFG_SRC_IN == 2'h2 |-> !CRYSTAL_OUT_PIN_OE_OUT) else $error("pin driven");
  rtc_block_a: assert property ((RTC_USES_XTAL_IN && !PORT_OE_IN)[*2] |-> !CRYSTAL_OUT_PIN_OE_OUT)
    else $error("clock out with rtc");
  // Bus answers
  ready_high_a: assert property (PREADY_OUT) else $error("pready low");
  err_map_a: assert property (PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == unmapped) else $error("pslverr");
  rd_zero_a: assert property (PSEL_IN && !PENABLE_IN && unmapped |=> PRDATA_OUT == 32'h0) else $error("prdata");
  upper_zero_a: assert property (PRDATA_OUT[31:8] == 24'h0) else $error("upper read bits");
  reset_quiet_a: assert property (disable iff (1'b0) RST_IN |=> !CPU_TICK_OUT && !CRYSTAL_OUT_PIN_OE_OUT)
    else $error("active in reset");
  // Main scenarios reached
  cover property (CPU_TICK_OUT ##1 MACHINE_TICK_OUT);
  cover property (PSLVERR_OUT);
  cover property (CRYSTAL_OUT_PIN_OE_OUT && OSC_TICK_OUT);
endmodule

bind ccg_top ccg_top_checker #(.FACTORY_TRIM_VAL(FACTORY_TRIM_VAL)) chk_i
(
  .REF_CLK_IN, .RST_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT,
  .PSLVERR_OUT, .CFG_SRC_IN, .RTC_USES_XTAL_IN, .PORT_OE_IN, .CRYSTAL_OUT_PIN_OE_OUT,
  .OSC_TICK_OUT, .CPU_TICK_OUT, .MACHINE_TICK_OUT, .PERIPH_TICK_OUT
);

/* File: tb/ccg_top_tb.sv */
// Self-checking bench for the clock source and output control block
`timescale 1ns/1ps
module ccg_top_tb;
  localparam logic [5:0] FAC = ccg_pkg::FACTORY_TRIM;
  // Bench drive and design outputs
  logic        clk, rst, srst, psel, pen, pwr, xin, rtc, pdat, poe, er;
  logic        prdy, perr, xo, xoe, osc, cpu, mach, per;
  logic [1:0]  src, rng;
  logic [5:0]  t;
  logic [7:0]  dv;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd, seed;
  int          error_cnt, cmp_count, cyc, g, e, xh;

  ccg_top uut
  (
    .REF_CLK_IN(clk), .RST_IN(rst), .SYS_RST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(4'hF), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .CFG_SRC_IN(src), .CFG_RANGE_IN(rng),
    .CRYSTAL_IN_PIN_IN(xin), .RTC_USES_XTAL_IN(rtc), .PORT_DATA_IN(pdat), .PORT_OE_IN(poe),
    .CRYSTAL_OUT_PIN_OUT(xo), .CRYSTAL_OUT_PIN_OE_OUT(xoe), .OSC_TICK_OUT(osc),
    .CPU_TICK_OUT(cpu), .MACHINE_TICK_OUT(mach), .PERIPH_TICK_OUT(per)
  );

  // Reference clock, 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard; also paces the pin clock, idle while xh is zero
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (xh != 0 && cyc % xh == 0)
      xin <= ~xin;
    if (cyc == 90000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ***************************************
  // Helpers
  // ***************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // RC period in reference cycles for a trim value
  function automatic int rcp(input logic [5:0] v);
    return 2 * (ccg_pkg::RC_NOM_HALF - int'(FAC) + int'(v));
  endfunction

  task close_out();
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, x);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Cycles between two rises: 0 osc, 1 cpu, 2 machine, 3 pin
  task gap(input int s, output int n);
    logic c, p;
    int   k;
    p = 1'b1;
    k = 0;
    n = 0;
    while (k < 2)
    begin
      @(negedge clk);
      c = (s == 0) ? osc : (s == 1) ? cpu : (s == 2) ? mach : xo;
      if (k == 1)
        n++;
      if (c && (s < 3 || !p))
        k++;
      p = c;
    end
  endtask

  // Power-on reset with new straps, then status and trim reload
  task por(input logic [1:0] s, input int n);
    seed = nxt(seed);
    rst <= 1'b1;
    src <= s;
    rng <= seed[1:0];
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ccg_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'({rng, s}));
    apb(1'b0, ccg_pkg::ADDR_TRIM, 32'h0);
    chk(rd, 32'(FAC));
  endtask

  // Main sequence
  initial
  begin
    {rst, srst, psel, pen, pwr, xin, rtc, pdat, poe} = 9'h100;
    {src, rng, pa, pwd} = '0;
    seed = 32'hAD90;
    {error_cnt, cmp_count, cyc, xh} = '0;
    por(2'h1, 12);
    apb(1'b0, 12'h000, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    // Trim corners and random values: read back and RC period
    for (int i = 0; i < 4; i++)
    begin
      seed = nxt(seed);
      t = (i == 0) ? FAC : (i == 1) ? 6'h00 : (i == 2) ? 6'h3F : seed[5:0];
      apb(1'b1, ccg_pkg::ADDR_TRIM, 32'(t));
      apb(1'b0, ccg_pkg::ADDR_TRIM, 32'h0);
      chk(rd, 32'(t));
      gap(0, g);
      gap(0, g);
      chk(32'(g), 32'(rcp(t)));
    end
    apb(1'b1, ccg_pkg::ADDR_TRIM, 32'(FAC));
    // Divider values including zero and the top count
    for (int i = 0; i < 4; i++)
    begin
      seed = nxt(seed);
      dv = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? {5'h0, seed[2:0]} : 8'hFF;
      apb(1'b1, ccg_pkg::ADDR_CPU_CLOCK_DIVIDER, 32'(dv));
      gap(1, g);
      gap(1, g);
      e = (dv == 8'h00) ? rcp(FAC) : 2 * int'(dv) * rcp(FAC);
      chk(32'(g), 32'(e));
      if (i < 3)
      begin
        gap(2, g);
        chk(32'(g), 32'(2 * e));
      end
    end
    apb(1'b1, ccg_pkg::ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    // Clock out set by read-modify-write, then blocked by the RTC
    apb(1'b0, ccg_pkg::ADDR_TRIM, 32'h0);
    apb(1'b1, ccg_pkg::ADDR_TRIM, rd | 32'h40);
    gap(3, g);
    gap(3, g);
    chk(32'(g), 32'(2 * rcp(FAC)));
    chk(32'(xoe), 32'h1);
    // Back onto the rising edge before driving pins
    @(posedge clk);
    rtc  <= 1'b1;
    pdat <= seed[9];
    repeat (4) @(posedge clk);
    chk(32'(xoe), 32'h0);
    poe <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({xoe, xo}), 32'({1'b1, seed[9]}));
    rtc <= 1'b0;
    poe <= 1'b0;
    // Other reset keeps the tuning register
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, ccg_pkg::ADDR_TRIM, 32'h0);
    chk(rd, 32'({2'b01, FAC}));
    // Watchdog source, then RC override without reset
    por(2'h0, 3);
    gap(0, g);
    gap(0, g);
    chk(32'(g), 32'(2 * ccg_pkg::WDT_HALF));
    apb(1'b1, ccg_pkg::ADDR_TRIM, 32'({2'b10, FAC}));
    gap(0, g);
    gap(0, g);
    chk(32'(g), 32'(rcp(FAC)));
    apb(1'b0, ccg_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[4]), 32'h1);
    // Crystal source: pin clock used, output pin left alone
    por(2'h2, 3);
    // Pin period of 18 cycles keeps it under 12 MHz: no reset pin duty
    xh <= 9;
    apb(1'b1, ccg_pkg::ADDR_TRIM, 32'({2'b01, FAC}));
    gap(0, g);
    gap(0, g);
    chk(32'(g), 32'h12);
    chk(32'(xoe), 32'h0);
    // External source: clock out at half the CPU rate
    @(posedge clk);
    por(2'h3, 3);
    apb(1'b1, ccg_pkg::ADDR_TRIM, 32'({2'b01, FAC}));
    gap(3, g);
    gap(3, g);
    chk(32'(g), 32'h24);
    close_out();
  end
endmodule
